// *** hdl/pirr_regs.svh ***
`ifndef PIRR_REGS_SVH
`define PIRR_REGS_SVH

// Interrupt input counts per mode, shared line and dynamic function counts
`define PIRR_LEGACY_INPUTS 16
`define PIRR_ADV_INPUTS 24
`define PIRR_LINES 8
`define PIRR_DYN_FUNCS 3
// Legacy inputs that a shared line may be steered onto: 3-7, 9-12, 14, 15
`define PIRR_LEGAL_MASK 16'hdef8
// Reset values of the steering settings
`define PIRR_STEER_OFF 4'h0
`define PIRR_SERIAL_DEF 4'h4
`define PIRR_PRINTER_DEF 4'h7
`define PIRR_DYN_DEF 3'h0
// Fixed input numbers
`define PIRR_IRQ_TIMER 0
`define PIRR_IRQ_KBD 1
`define PIRR_IRQ_CASCADE 2
`define PIRR_IRQ_RTC 8
`define PIRR_IRQ_FPU 13
`define PIRR_IRQ_DISK_PRI 14
`define PIRR_IRQ_DISK_SEC 15
`define PIRR_ADV_BASE 16

`endif

// *** hdl/pirr_pkg.sv ***
`include "pirr_regs.svh"

package pirr_pkg;

  typedef enum logic {PIRR_LEGACY, PIRR_ADVANCED} pirr_mode_t;
  typedef logic [3:0] pirr_sel_t;
  typedef logic [2:0] pirr_line_sel_t;

  // One-hot legacy input for a steering choice; illegal choices map to none
  function automatic logic [15:0] pirr_route(input pirr_sel_t sel);
    pirr_route = (16'h0001 << sel) & `PIRR_LEGAL_MASK;
  endfunction

  // One-hot shared line for an active-low source with a line choice
  function automatic logic [7:0] pirr_line_hit(input logic req_n, input pirr_line_sel_t sel);
    pirr_line_hit = req_n ? 8'h00 : (8'h01 << sel);
  endfunction

endpackage

// *** hdl/pirr_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface pirr_if;
  logic [7:0] line_req;
  pirr_pkg::pirr_sel_t [7:0] line_sel;
  logic [15:0] steer_irq;

  modport steer (input line_req, input line_sel, output steer_irq);
  modport top (output line_req, output line_sel, input steer_irq);
endinterface

`default_nettype wire

// *** hdl/pirr_steer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pirr_regs.svh"

module pirr_steer (
  pirr_if.steer sif
);

  wire [15:0] acc [0:8];

  assign acc[0] = 16'h0000;

  // Each line lands on one legacy input, or none for an illegal choice; lines sharing an input merge
  genvar i;
  generate
    for (i = 0; i < `PIRR_LINES; i = i + 1) begin : g_line
      assign acc[i+1] = acc[i] | (sif.line_req[i] ? pirr_pkg::pirr_route(sif.line_sel[i]) : 16'h0000);
    end
  endgenerate

  assign sif.steer_irq = acc[8];

endmodule

`default_nettype wire

// *** hdl/pirr_top.sv ***
// Functional notes
// - Legacy mode uses only interrupt inputs 0 to 15.
// - Advanced mode supports 24 interrupt inputs, 0 to 23.
// - Eight shared request lines A-H; every PCI source drives exactly one.
// - Sources on the same line are combined into one common request.
// - Legacy mode steers each line to one of 3-7, 9-12, 14, 15.
// - Several lines may be steered to one input; their requests merge.
// - Advanced mode puts lines A-H on inputs 16-23; absent in legacy mode.
// - Inputs 0 timer, 1 keyboard, 2 cascade, 8 real-time clock, 13 coprocessor.
// - Serial port defaults to input 4, printer to 7; both reassignable.
// - Disk channels use 14 and 15; freed when the channel is absent.
// - Slot 1 A-D to F,G,H,E; slot 2 A-D to G,F,E,H.
// - Slot 3 A-D to C,D,B,A; slot 4 A-D to D,C,F,G.
// - Network controller on line E, serial-bus controller on line B.
// - On-chip serial-bus, disk and PCIe port functions are routed dynamically.
`timescale 1ns/1ps
`default_nettype none
`include "pirr_regs.svh"

module pirr_top (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] SLOT1_INT_N,
  input wire logic [3:0] SLOT2_INT_N,
  input wire logic [3:0] SLOT3_INT_N,
  input wire logic [3:0] SLOT4_INT_N,
  input wire logic LAN_INT_N,
  input wire logic SBUS_INT_N,
  input wire logic [2:0] DYN_INT_N,
  input wire logic TIMER_IRQ,
  input wire logic KBD_IRQ,
  input wire logic CASCADE_IRQ,
  input wire logic DISKETTE_IRQ,
  input wire logic RTC_IRQ,
  input wire logic MOUSE_IRQ,
  input wire logic FPU_IRQ,
  input wire logic SERIAL_IRQ,
  input wire logic PRINTER_IRQ,
  input wire logic DISK_PRI_IRQ,
  input wire logic DISK_SEC_IRQ,
  input wire logic CFG_LOAD,
  input wire logic CFG_ADVANCED,
  input wire logic [31:0] CFG_STEER,
  input wire logic [3:0] CFG_SERIAL_IRQ,
  input wire logic [3:0] CFG_PRINTER_IRQ,
  input wire logic CFG_DISK_PRI,
  input wire logic CFG_DISK_SEC,
  input wire logic [8:0] CFG_DYN_LINE,
  output logic [23:0] CTRL_IRQ,
  output logic [7:0] SHARED_LINE_N
);

  pirr_if sif ();

  pirr_pkg::pirr_mode_t mode_q;
  pirr_pkg::pirr_sel_t [7:0] steer_q;
  pirr_pkg::pirr_sel_t serial_sel_q;
  pirr_pkg::pirr_sel_t printer_sel_q;
  pirr_pkg::pirr_line_sel_t [2:0] dyn_sel_q;
  logic disk_pri_q;
  logic disk_sec_q;
  logic [23:0] irq_q;
  logic [7:0] shared_n_q;

  wire [7:0] dyn_hit;
  wire [7:0] line_req_d;
  wire [15:0] dev_irq;
  wire [15:0] port_irq;
  wire [15:0] legacy_irq;
  wire [23:0] irq_d;
  wire adv;
  wire disk_pri_irq;
  wire disk_sec_irq;

  pirr_steer u_steer (
    .sif(sif)
  );

  assign adv = (mode_q == pirr_pkg::PIRR_ADVANCED);

  // Dynamic functions land on whichever line software picked
  assign dyn_hit = pirr_pkg::pirr_line_hit(DYN_INT_N[0], dyn_sel_q[0])
                 | pirr_pkg::pirr_line_hit(DYN_INT_N[1], dyn_sel_q[1])
                 | pirr_pkg::pirr_line_hit(DYN_INT_N[2], dyn_sel_q[2]);

  // Wired-AND of active-low sources per line, seen as active-high requests
  assign line_req_d[0] = !SLOT3_INT_N[3] | dyn_hit[0];
  assign line_req_d[1] = !SLOT3_INT_N[2] | !SBUS_INT_N | dyn_hit[1];
  assign line_req_d[2] = !SLOT3_INT_N[0] | !SLOT4_INT_N[1] | dyn_hit[2];
  assign line_req_d[3] = !SLOT3_INT_N[1] | !SLOT4_INT_N[0] | dyn_hit[3];
  assign line_req_d[4] = !SLOT1_INT_N[3] | !SLOT2_INT_N[2] | !LAN_INT_N | dyn_hit[4];
  assign line_req_d[5] = !SLOT1_INT_N[0] | !SLOT2_INT_N[1] | !SLOT4_INT_N[2] | dyn_hit[5];
  assign line_req_d[6] = !SLOT1_INT_N[1] | !SLOT2_INT_N[0] | !SLOT4_INT_N[3] | dyn_hit[6];
  assign line_req_d[7] = !SLOT1_INT_N[2] | !SLOT2_INT_N[3] | dyn_hit[7];

  assign sif.line_req = line_req_d;
  assign sif.line_sel = steer_q;

  // Fixed board sources; disk inputs are free when the channel is absent
  assign disk_pri_irq = DISK_PRI_IRQ & disk_pri_q;
  assign disk_sec_irq = DISK_SEC_IRQ & disk_sec_q;
  assign dev_irq = {disk_sec_irq, disk_pri_irq, FPU_IRQ, MOUSE_IRQ,
                    3'h0, RTC_IRQ, 1'b0, DISKETTE_IRQ, 3'h0, CASCADE_IRQ, KBD_IRQ, TIMER_IRQ};

  assign port_irq = (SERIAL_IRQ ? pirr_pkg::pirr_route(serial_sel_q) : 16'h0000)
                  | (PRINTER_IRQ ? pirr_pkg::pirr_route(printer_sel_q) : 16'h0000);

  // Steering only applies in legacy mode
  assign legacy_irq = dev_irq | port_irq | (adv ? 16'h0000 : sif.steer_irq);

  assign irq_d = adv ? {line_req_d, legacy_irq} : {8'h00, legacy_irq};

  // Settings
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mode_q <= pirr_pkg::PIRR_LEGACY;
      steer_q <= {`PIRR_LINES{`PIRR_STEER_OFF}};
      serial_sel_q <= `PIRR_SERIAL_DEF;
      printer_sel_q <= `PIRR_PRINTER_DEF;
      dyn_sel_q <= {`PIRR_DYN_FUNCS{`PIRR_DYN_DEF}};
      disk_pri_q <= 1'b1;
      disk_sec_q <= 1'b1;
    end else if (CFG_LOAD) begin
      mode_q <= CFG_ADVANCED ? pirr_pkg::PIRR_ADVANCED : pirr_pkg::PIRR_LEGACY;
      steer_q <= CFG_STEER;
      serial_sel_q <= CFG_SERIAL_IRQ;
      printer_sel_q <= CFG_PRINTER_IRQ;
      dyn_sel_q <= CFG_DYN_LINE;
      disk_pri_q <= CFG_DISK_PRI;
      disk_sec_q <= CFG_DISK_SEC;
    end
  end

  // Registered outputs
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      irq_q <= 24'h000000;
      shared_n_q <= 8'hff;
    end else begin
      irq_q <= irq_d;
      shared_n_q <= ~line_req_d;
    end
  end

  assign CTRL_IRQ = irq_q;
  assign SHARED_LINE_N = shared_n_q;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  legacy_upper_a: assert property (CTRL_IRQ[23:16] != 8'h00 |-> $past(adv))
    else $error("upper inputs active in legacy mode");
  adv_lines_a: assert property (adv |=> CTRL_IRQ[23:16] == $past(line_req_d))
    else $error("shared lines not on inputs 16-23");
  steer_legal_a: assert property ((sif.steer_irq & ~`PIRR_LEGAL_MASK) == 16'h0000)
    else $error("line steered to a reserved input");
  steer_hit_a: assert property (!adv && line_req_d[0] && (pirr_pkg::pirr_route(steer_q[0]) != 16'h0000)
    |=> CTRL_IRQ[$past(steer_q[0])])
    else $error("steered line A request lost");
  slot1_map_a: assert property (!SLOT1_INT_N[0] && !SLOT2_INT_N[1] |=> !SHARED_LINE_N[5])
    else $error("slot INTA not on line F");
  slot3_map_a: assert property (!SLOT3_INT_N[3] |=> !SHARED_LINE_N[0] ##0 !SHARED_LINE_N[0])
    else $error("slot 3 INTD not on line A");
  lan_line_a: assert property (!LAN_INT_N |=> !SHARED_LINE_N[4])
    else $error("network request not on line E");
  reserved_a: assert property (TIMER_IRQ && RTC_IRQ && FPU_IRQ |=> CTRL_IRQ[0] && CTRL_IRQ[8] && CTRL_IRQ[13])
    else $error("reserved input not delivered");
  port_default_a: assert property ($past(SYS_RST) |-> serial_sel_q == 4'h4 && printer_sel_q == 4'h7)
    else $error("port defaults wrong after reset");
  disk_free_a: assert property (DISK_PRI_IRQ && !disk_pri_q && !adv && sif.steer_irq[14] == 1'b0
    && port_irq[14] == 1'b0 |=> !CTRL_IRQ[14])
    else $error("absent disk channel still drives input 14");
  dyn_route_a: assert property (!DYN_INT_N[0] |=> !SHARED_LINE_N[$past(dyn_sel_q[0])])
    else $error("dynamic function not on chosen line");
  line_release_a: assert property (SHARED_LINE_N[1] == 1'b0 |-> $past(line_req_d[1]))
    else $error("line asserted with no source");

  legacy_clear_a: assert property (!adv |=> CTRL_IRQ[23:16] == 8'h00)
    else $error("upper inputs not clear in legacy mode");
  adv_no_steer_a: assert property (adv && (dev_irq | port_irq) == 16'h0000 |=> CTRL_IRQ[15:0] == 16'h0000)
    else $error("steering applied in advanced mode");
  merge_hit_a: assert property (!adv && line_req_d[1] && (pirr_pkg::pirr_route(steer_q[1]) != 16'h0000)
    |=> CTRL_IRQ[$past(steer_q[1])])
    else $error("steered line B request lost");
  slot1_intd_a: assert property (!SLOT1_INT_N[3] |=> !SHARED_LINE_N[4])
    else $error("slot 1 INTD not on line E");
  slot2_inta_a: assert property (!SLOT2_INT_N[0] |=> !SHARED_LINE_N[6])
    else $error("slot 2 INTA not on line G");
  slot4_inta_a: assert property (!SLOT4_INT_N[0] |=> !SHARED_LINE_N[3])
    else $error("slot 4 INTA not on line D");
  slot4_intc_a: assert property (!SLOT4_INT_N[2] |=> !SHARED_LINE_N[5])
    else $error("slot 4 INTC not on line F");
  sbus_line_a: assert property (!SBUS_INT_N |=> !SHARED_LINE_N[1])
    else $error("serial-bus request not on line B");
  kbd_cascade_a: assert property (KBD_IRQ && CASCADE_IRQ |=> CTRL_IRQ[`PIRR_IRQ_KBD] && CTRL_IRQ[`PIRR_IRQ_CASCADE])
    else $error("keyboard or cascade input not delivered");
  serial_route_a: assert property (SERIAL_IRQ && (pirr_pkg::pirr_route(serial_sel_q) != 16'h0000)
    |=> CTRL_IRQ[$past(serial_sel_q)])
    else $error("serial request not on chosen input");
  printer_route_a: assert property (PRINTER_IRQ && (pirr_pkg::pirr_route(printer_sel_q) != 16'h0000)
    |=> CTRL_IRQ[$past(printer_sel_q)])
    else $error("printer request not on chosen input");
  disk_present_a: assert property (disk_pri_irq |=> CTRL_IRQ[`PIRR_IRQ_DISK_PRI])
    else $error("present disk channel not on input 14");
  disk_sec_free_a: assert property (DISK_SEC_IRQ && !disk_sec_q && !adv && sif.steer_irq[15] == 1'b0
    && port_irq[15] == 1'b0 |=> !CTRL_IRQ[15])
    else $error("absent disk channel still drives input 15");
  dyn_func2_a: assert property (!DYN_INT_N[2] |=> !SHARED_LINE_N[$past(dyn_sel_q[2])])
    else $error("third dynamic function not on chosen line");
  line_hold_a: assert property (line_req_d[4] |=> !SHARED_LINE_N[4])
    else $error("line E not asserted while requested");
  line_free_a: assert property (!line_req_d[7] |=> SHARED_LINE_N[7])
    else $error("line H asserted with no source");

  legacy_steer_c: cover property (!adv && line_req_d[0] ##1 sif.steer_irq != 16'h0000);
  adv_line_c: cover property (adv && line_req_d[7] ##1 CTRL_IRQ[23]);
  merge_c: cover property (!adv && line_req_d[0] && line_req_d[1] && steer_q[0] == steer_q[1]);
  serial_moved_c: cover property (SERIAL_IRQ && serial_sel_q != `PIRR_SERIAL_DEF);
  dyn_line_c: cover property (!DYN_INT_N[1] ##1 !SHARED_LINE_N[6]);

endmodule

`default_nettype wire

// *** tb/pirr_card_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pirr_card_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [20:0] raise,
  input wire logic [20:0] done,
  output logic [20:0] src_n
);
  // Level held low until serviced
  always_ff @(posedge clk) begin
    if (rst) begin
      src_n <= '1;
    end else begin
      src_n <= (src_n & ~raise) | done;
    end
  end
endmodule

`default_nettype wire

// *** tb/test_pci_interrupt_line_router.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_pci_interrupt_line_router;
  logic clk, rst, load, adv, dpri, dsec;
  logic [20:0] raise, done, src_n;
  logic [10:0] fix;
  logic [31:0] steer;
  logic [3:0] ser, prn;
  logic [8:0] dyn;
  logic [23:0] irq;
  logic [7:0] line_n;
  int errors, n_checks;
  int lmap[21] = '{5, 6, 7, 4, 6, 5, 4, 7, 2, 3, 1, 0, 3, 2, 5, 6, 4, 1, 5, 6, 7};
  int legal[13] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15, 13, 8};

  pirr_card_model cards (.clk(clk), .rst(rst), .raise(raise), .done(done), .src_n(src_n));
  pirr_top dut (.REF_CLK(clk), .SYS_RST(rst), .SLOT1_INT_N(src_n[3:0]), .SLOT2_INT_N(src_n[7:4]),
    .SLOT3_INT_N(src_n[11:8]), .SLOT4_INT_N(src_n[15:12]), .LAN_INT_N(src_n[16]), .SBUS_INT_N(src_n[17]),
    .DYN_INT_N(src_n[20:18]), .TIMER_IRQ(fix[0]), .KBD_IRQ(fix[1]), .CASCADE_IRQ(fix[2]),
    .DISKETTE_IRQ(fix[3]), .RTC_IRQ(fix[4]), .MOUSE_IRQ(fix[5]), .FPU_IRQ(fix[6]), .SERIAL_IRQ(fix[7]),
    .PRINTER_IRQ(fix[8]), .DISK_PRI_IRQ(fix[9]), .DISK_SEC_IRQ(fix[10]), .CFG_LOAD(load),
    .CFG_ADVANCED(adv), .CFG_STEER(steer), .CFG_SERIAL_IRQ(ser), .CFG_PRINTER_IRQ(prn),
    .CFG_DISK_PRI(dpri), .CFG_DISK_SEC(dsec), .CFG_DYN_LINE(dyn), .CTRL_IRQ(irq), .SHARED_LINE_N(line_n));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg(input logic a, input logic [31:0] s, input logic [3:0] sr, input logic [3:0] pr, input logic d);
    adv = a;
    steer = s;
    ser = sr;
    prn = pr;
    dpri = d;
    dsec = d;
    dyn = 9'h1f5;
    load = 1'b1;
    step(1);
    load = 1'b0;
    step(2);
  endtask

  task automatic complete_run();
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Fixed inputs, serial/printer defaults and moves, disk channels
  task automatic test_fixed();
    fix = '1;
    step(2);
    chk("fixed default", 24'h00f1d7, irq);
    cfg(1'b0, '0, 4'ha, 4'hb, 1'b0);
    chk("fixed moved", 24'h003d47, irq);
    fix = '0;
    step(2);
  endtask

  // Every source onto its line, lines on 16-23, steering ignored
  task automatic test_wiring();
    cfg(1'b1, 32'h99999999, 4'h0, 4'h0, 1'b1);
    for (int i = 0; i < 21; i++) begin
      raise[i] = 1'b1; // Cards use INTA first
      step(1);
      raise[i] = 1'b0;
      step(2);
      chk("line", {16'h0, ~(8'h01 << lmap[i])}, {16'h0, line_n});
      chk("adv irq", 24'h010000 << lmap[i], irq);
      done[i] = 1'b1;
      step(1);
      done[i] = 1'b0;
      step(2);
      chk("released", {16'h0, 8'hff}, {16'h0, line_n});
    end
  endtask

  // All lines on one legal input, two sources merged; illegal values dropped
  task automatic test_steer();
    logic [3:0] v;
    for (int k = 0; k < 13; k++) begin
      v = 4'(legal[k]);
      cfg(1'b0, {8{v}}, 4'h0, 4'h0, 1'b0);
      raise[11] = 1'b1;
      raise[17] = 1'b1;
      step(1);
      raise = '0;
      step(2);
      chk("steer", (k < 11) ? (24'h000001 << v) : 24'h0, irq);
      done[11] = 1'b1;
      step(1);
      done = '0;
      step(2);
      chk("held", (k < 11) ? (24'h000001 << v) : 24'h0, irq);
      done[17] = 1'b1;
      step(1);
      done = '0;
      step(2);
      chk("idle", 24'h0, irq);
    end
  endtask

  initial begin
    rst = 1'b1;
    {load, adv, dpri, dsec, raise, done, fix, steer, ser, prn, dyn} = '0;
    step(20);
    chk("reset irq", 24'h0, irq);
    rst = 1'b0;
    step(1);
    chk("reset lines", {16'h0, 8'hff}, {16'h0, line_n});
    test_fixed();
    test_wiring();
    test_steer();
    complete_run();
  end

  initial begin
    #100us;
    errors++;
    complete_run();
  end
endmodule

`default_nettype wire
